/* smc_pkg.sv */
// Shared constants and carrier types for the serial memory command block.
// Assumes a single SPI link with byte-wise command, address and data phases.
package smc_pkg;
   localparam logic [7:0] OP_WRITE_LATCH_SET   = 8'h06;
   localparam logic [7:0] OP_WRITE_LATCH_CLEAR = 8'h04;
   localparam logic [7:0] OP_REG_READ_ADDR     = 8'h65;
   localparam logic [7:0] OP_REG_WRITE_ADDR    = 8'h71;
   localparam logic [7:0] OP_READ_A            = 8'h03;
   localparam logic [7:0] OP_READ_B            = 8'h13;
   localparam logic [7:0] OP_FAST_READ_A       = 8'h0b;
   localparam logic [7:0] OP_FAST_READ_B       = 8'h0c;
   localparam logic [7:0] OP_DDR_READ          = 8'h0d;
   localparam logic [7:0] OP_QUAD_OUT_READ     = 8'h6b;
   localparam logic [7:0] OP_QUAD_IO_READ      = 8'heb;
   localparam logic [7:0] OP_QUAD_IO_DDR_READ  = 8'hed;
   localparam logic [7:0] OP_WRITE_SINGLE      = 8'h02;
   localparam logic [7:0] OP_WRITE_FAST        = 8'hda;
   localparam logic [7:0] OP_WRITE_DDR         = 8'hde;
   localparam logic [7:0] OP_WRITE_QUAD        = 8'hd2;
   // Register addresses used by the address-based register commands.
   localparam logic [31:0] ADDR_CFG1      = 32'h0000_0002;
   localparam logic [31:0] ADDR_CFG2      = 32'h0000_0003;
   localparam logic [31:0] ADDR_INTCTL    = 32'h0000_0004;
   localparam logic [31:0] ADDR_UID       = 32'h0000_0010;
   localparam logic [31:0] ADDR_TEST_IN   = 32'h0000_0020;
   localparam logic [31:0] ADDR_TEST_MASK = 32'h0000_0024;
   localparam logic [31:0] ADDR_TEST_OUT  = 32'h0000_0028;
   localparam logic [31:0] ADDR_ERR_CNT   = 32'h0000_002c;
   localparam logic [7:0] CFG1_RESET = 8'h61;
   localparam logic [7:0] CFG2_RESET = 8'h00;
   localparam logic [7:0] INTCTL_RESET = 8'h00;
   localparam logic [31:0] WORD_RESET = 32'h0000_0000;
   localparam logic [1:0] POL_NORMAL = 2'h0;
   localparam logic [1:0] POL_SRAM   = 2'h1;
   localparam logic [1:0] POL_B2B    = 2'h2;
   localparam int CFG1_LOCK_BIT = 2;
   localparam int INT_EN_BIT = 0;
   localparam int INT_TEST_BIT = 1;
   localparam int INT_CNTCLR_BIT = 5;
   localparam int INT_CLR_BIT = 6;
   localparam logic [2:0] BYTE_ADDR_LAST = 3'h4;
   localparam logic [63:0] UID_VALUE = 64'h0123_4567_89ab_cdef;  // Arbitrary value.
   typedef struct packed
   {
      logic corrected;
      logic uncorrectable;
   } smc_ecc_evt_t;
   typedef struct packed
   {
      logic       top_bottom;
      logic [2:0] block_protect;
   } smc_protect_t;
endpackage

/* smc_cmd.sv */
// Command interpreter with configuration and ECC test registers of a serial persistent memory.
// Assumes the SPI clock runs only inside frames; array access logic sits outside this block.
//
// Function
// RULE1: 64-bit unique identifier is read-only; writes ignored.
// RULE2: Protection lock bit blocks changes to top/bottom and block-protect bits.
// RULE3: Config1 bits 7:5 select drive impedance, default 011.
// RULE4: Normal policy: latch required for array write, cleared at chip select rise.
// RULE5: SRAM policy 01 accepts array writes without latch; reset default.
// RULE6: Back-to-back policy keeps latch after writes; 11 reserved.
// RULE7: Register writes always need the latch and clear it afterwards.
// RULE8: Config2 bits 3:0 give read latency 0..15; upper bits read zero.
// RULE9: Interrupt enable bit drives interrupt output low on ECC error.
// RULE10: Control bit 7 reads one after unrecoverable error.
// RULE11: Writing one to control bit 6 clears the pending interrupt.
// RULE12: Control bit 1 enables ECC test; bits 3:2 select die.
// RULE13: Test mode loads test input word into engine buffer.
// RULE14: Buffered test data is XORed with error mask.
// RULE15: Test result shows in read-only output word, reset zero.
// RULE16: Error counter counts corrected errors; control bit 5 clears it.
// RULE17: Host programs 8..15 latency for continuous-mode reads.
// RULE18: Host keeps zero-latency single reads at or below 50 MHz.
// RULE19: Register read 65h: address, latency, one byte; write 71h needs latch.
// RULE20: Write opcodes 02h, DAh, DEh, D2h take address then data.
// RULE21: Reads 03h and 13h stream data without latency.
// RULE22: Fast and quad reads insert configured latency after address.
// RULE23: Latch set only by set command, cleared by clear command.
// RULE24: Command then 32-bit address, MSB first.
// RULE25: Mode byte upper nibble A enters, F leaves continuous mode.
// RULE26: Reserved bits read zero; reserved policy acts as normal.
// RULE27: Interrupt stays low until cleared by software.
`timescale 1ns/1ns
module smc_cmd
   import smc_pkg::*;
(
   input  wire logic         i_clk,
   input  wire logic         i_rst,
   input  wire logic         i_sck,
   input  wire logic         i_cs_n,
   input  wire logic         i_si,
   input  wire smc_ecc_evt_t i_ecc_evt,
   input  wire smc_protect_t i_protect_req,
   output logic              o_so,
   output logic              o_so_oe,
   output logic              o_int_n,
   output logic [2:0]        o_drive_impedance_select,
   output logic              o_array_write_ok,
   output smc_protect_t      o_protect,
   output logic [31:0]       o_test_out
);
   typedef enum logic [2:0] {ST_CMD, ST_ADDR, ST_MODE, ST_LAT, ST_DATA, ST_IGNORE} smc_state_t;

   // Link domain: shifts command, address and data on the SPI clock.
   smc_state_t   state_ff;
   logic [2:0]   bit_ff;
   logic [2:0]   byte_ff;
   logic [7:0]   shift_ff;
   logic [7:0]   op_ff;
   logic [31:0]  addr_ff;
   logic [3:0]   lat_ff;
   logic         xip_ff;
   logic [7:0]   rd_byte_ff;
   logic         so_ff;
   logic         so_oe_ff;
   logic         wr_tgl_ff;
   logic [7:0]   wr_data_ff;
   logic [31:0]  wr_addr_ff;
   logic         wr_reg_ff;
   logic         set_tgl_ff;
   logic         clr_tgl_ff;
   logic         aw_tgl_ff;
   logic         end_tgl_ff;
   logic [7:0]   nxt_byte;
   logic         is_read_lat;
   logic         is_read_plain;
   logic         is_write_arr;
   logic         is_reg_read;
   logic         is_reg_write;
   logic [3:0]   lat_cfg;
   logic [7:0]   reg_rd;

   assign nxt_byte = {shift_ff[6:0], i_si};  // RULE24
   assign is_read_plain = (op_ff == OP_READ_A) || (op_ff == OP_READ_B);
   assign is_read_lat = (op_ff == OP_FAST_READ_A) || (op_ff == OP_FAST_READ_B) || (op_ff == OP_DDR_READ)
                        || (op_ff == OP_QUAD_OUT_READ) || (op_ff == OP_QUAD_IO_READ)
                        || (op_ff == OP_QUAD_IO_DDR_READ);
   assign is_write_arr = (op_ff == OP_WRITE_SINGLE) || (op_ff == OP_WRITE_FAST) || (op_ff == OP_WRITE_DDR)
                         || (op_ff == OP_WRITE_QUAD);
   assign is_reg_read = op_ff == OP_REG_READ_ADDR;
   assign is_reg_write = op_ff == OP_REG_WRITE_ADDR;

   // Frame logic is held in reset while chip select is high, so each frame starts clean.
   always_ff @(posedge i_sck or posedge i_cs_n)
   begin
      if (i_cs_n)
      begin
         state_ff <= ST_CMD;
         bit_ff   <= 3'h0;
         byte_ff  <= 3'h0;
         shift_ff <= 8'h00;
         lat_ff   <= 4'h0;
      end
      else
      begin
         shift_ff <= nxt_byte;
         bit_ff   <= bit_ff + 3'h1;
         case (state_ff)
            ST_CMD:
            begin
               if (bit_ff == 3'h7)
               begin
                  byte_ff  <= 3'h0;
                  state_ff <= (nxt_byte == OP_WRITE_LATCH_SET || nxt_byte == OP_WRITE_LATCH_CLEAR)
                              ? ST_IGNORE : ST_ADDR;  // RULE24
               end
            end
            ST_ADDR:
            begin
               if (bit_ff == 3'h7)
               begin
                  byte_ff <= byte_ff + 3'h1;
                  if (byte_ff + 3'h1 == BYTE_ADDR_LAST)
                  begin
                     lat_ff <= lat_cfg;
                     if (is_read_lat)
                        state_ff <= ST_MODE;  // RULE22
                     else if (is_reg_read && lat_cfg != 4'h0)
                        state_ff <= ST_LAT;  // RULE19
                     else
                        state_ff <= ST_DATA;  // RULE20 RULE21
                  end
               end
            end
            ST_MODE:
            begin
               if (bit_ff == 3'h7)
                  state_ff <= (lat_ff == 4'h0) ? ST_DATA : ST_LAT;
            end
            ST_LAT:
            begin
               lat_ff <= lat_ff - 4'h1;
               if (lat_ff == 4'h1)
               begin
                  state_ff <= ST_DATA;  // RULE8 RULE19
                  bit_ff   <= 3'h0;
               end
            end
            ST_DATA:
               state_ff <= ST_DATA;
            default:
               state_ff <= ST_IGNORE;
         endcase
      end
   end

   // Captured command, address and mode byte kept across the frame end for the core domain.
   always_ff @(posedge i_sck or posedge i_rst)
   begin
      if (i_rst)
      begin
         op_ff      <= 8'h00;
         addr_ff    <= 32'h0;
         xip_ff     <= 1'b0;
         wr_tgl_ff  <= 1'b0;
         wr_data_ff <= 8'h00;
         wr_addr_ff <= 32'h0;
         wr_reg_ff  <= 1'b0;
         set_tgl_ff <= 1'b0;
         clr_tgl_ff <= 1'b0;
         aw_tgl_ff  <= 1'b0;
      end
      else if (!i_cs_n)
      begin
         if (state_ff == ST_CMD && bit_ff == 3'h7)
         begin
            op_ff <= nxt_byte;
            if (nxt_byte == OP_WRITE_LATCH_SET)
               set_tgl_ff <= ~set_tgl_ff;  // RULE23
            if (nxt_byte == OP_WRITE_LATCH_CLEAR)
               clr_tgl_ff <= ~clr_tgl_ff;  // RULE23
         end
         if (state_ff == ST_ADDR)
            addr_ff <= {addr_ff[30:0], i_si};  // RULE24
         if (state_ff == ST_MODE && bit_ff == 3'h7)
         begin
            if (nxt_byte[7:4] == 4'ha)
               xip_ff <= 1'b1;  // RULE25
            else if (nxt_byte[7:4] == 4'hf)
               xip_ff <= 1'b0;  // RULE25
         end
         if (state_ff == ST_DATA && bit_ff == 3'h7 && (is_reg_write || is_write_arr))
         begin
            wr_data_ff <= nxt_byte;
            wr_addr_ff <= addr_ff;
            wr_reg_ff  <= is_reg_write;
            if (is_reg_write)
               wr_tgl_ff <= ~wr_tgl_ff;  // RULE19
            else
               aw_tgl_ff <= ~aw_tgl_ff;  // RULE20
         end
      end
   end

   // Read data leaves on the falling edge, MSB first.
   always_ff @(negedge i_sck or posedge i_cs_n)
   begin
      if (i_cs_n)
      begin
         so_ff      <= 1'b0;
         so_oe_ff   <= 1'b0;
         rd_byte_ff <= 8'h00;
      end
      else if (state_ff == ST_DATA && (is_reg_read || is_read_plain || is_read_lat))
      begin
         so_oe_ff <= 1'b1;
         if (bit_ff == 3'h0)
         begin
            so_ff      <= reg_rd[7];
            rd_byte_ff <= {reg_rd[6:0], 1'b0};
         end
         else
         begin
            so_ff      <= rd_byte_ff[7];
            rd_byte_ff <= {rd_byte_ff[6:0], 1'b0};
         end
      end
   end

   assign o_so    = so_ff;
   assign o_so_oe = so_oe_ff;

   // Frame end is marked by a toggle on the chip select rise.
   always_ff @(posedge i_cs_n or posedge i_rst)
   begin
      if (i_rst)
         end_tgl_ff <= 1'b0;
      else
         end_tgl_ff <= ~end_tgl_ff;
   end

   // Core domain: two-stage synchronisers for every toggle from the link side.
   logic [4:0] sy1_ff;
   logic [4:0] sy2_ff;
   logic [4:0] sy3_ff;
   logic [4:0] evt;
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         sy1_ff <= 5'h0;
         sy2_ff <= 5'h0;
         sy3_ff <= 5'h0;
      end
      else
      begin
         sy1_ff <= {end_tgl_ff, aw_tgl_ff, wr_tgl_ff, clr_tgl_ff, set_tgl_ff};
         sy2_ff <= sy1_ff;
         sy3_ff <= sy2_ff;
      end
   end
   assign evt = sy2_ff ^ sy3_ff;

   // Configuration and ECC registers.
   logic [7:0]   cfg1_ff;
   logic [3:0]   cfg2_ff;
   logic [7:0]   intctl_ff;
   logic [31:0]  test_in_ff;
   logic [31:0]  test_mask_ff;
   logic [31:0]  test_out_ff;
   logic [31:0]  err_cnt_ff;
   logic         latch_ff;
   logic         flag_ff;
   logic         int_n_ff;
   logic         pend_reg_ff;
   logic         pend_arr_ff;
   logic         aw_ok_ff;
   smc_protect_t prot_ff;
   logic         reg_wr_go;
   logic [1:0]   pol;

   assign lat_cfg = cfg2_ff;
   assign pol = cfg1_ff[1:0];
   assign reg_wr_go = evt[2] && wr_reg_ff && latch_ff;  // RULE7

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         cfg1_ff      <= CFG1_RESET;
         cfg2_ff      <= CFG2_RESET[3:0];
         intctl_ff    <= INTCTL_RESET;
         test_in_ff   <= WORD_RESET;
         test_mask_ff <= WORD_RESET;
      end
      else if (reg_wr_go)
      begin
         case (wr_addr_ff)
            ADDR_CFG1:    cfg1_ff <= {wr_data_ff[7:5], 2'b00, wr_data_ff[2:0]};  // RULE3 RULE26
            ADDR_CFG2:    cfg2_ff <= wr_data_ff[3:0];  // RULE8
            ADDR_INTCTL:  intctl_ff <= {4'h0, wr_data_ff[3:0]};  // RULE12 RULE9
            ADDR_TEST_IN: test_in_ff <= {test_in_ff[23:0], wr_data_ff};
            ADDR_TEST_MASK: test_mask_ff <= {test_mask_ff[23:0], wr_data_ff};
            default:      cfg2_ff <= cfg2_ff;  // RULE1
         endcase
      end
   end

   // Write-enable latch and array write permission.
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         latch_ff    <= 1'b0;
         pend_reg_ff <= 1'b0;
         pend_arr_ff <= 1'b0;
         aw_ok_ff    <= 1'b0;
      end
      else
      begin
         if (evt[0])
            latch_ff <= 1'b1;  // RULE23
         else if (evt[1])
            latch_ff <= 1'b0;  // RULE23
         else if (evt[4] && (pend_reg_ff || reg_wr_go
                             || ((pend_arr_ff || evt[3]) && pol != POL_B2B && pol != POL_SRAM)))
            latch_ff <= 1'b0;  // RULE4 RULE7 RULE26
         if (reg_wr_go)
            pend_reg_ff <= 1'b1;
         else if (evt[4])
            pend_reg_ff <= 1'b0;
         if (evt[3])
            pend_arr_ff <= 1'b1;
         else if (evt[4])
            pend_arr_ff <= 1'b0;
         aw_ok_ff <= (pol == POL_SRAM) || latch_ff;  // RULE4 RULE5 RULE6 RULE26
      end
   end

   // Block protection update obeys the lock bit.
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         prot_ff <= '0;
      else if (!cfg1_ff[CFG1_LOCK_BIT] && latch_ff)
         prot_ff <= i_protect_req;  // RULE2
   end

   // ECC test path, error counter, flag and interrupt.
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         test_out_ff <= WORD_RESET;
         err_cnt_ff  <= WORD_RESET;
         flag_ff     <= 1'b0;
         int_n_ff    <= 1'b1;
      end
      else
      begin
         if (intctl_ff[INT_TEST_BIT])
            test_out_ff <= test_in_ff ^ test_mask_ff;  // RULE13 RULE14 RULE15
         if (i_ecc_evt.corrected)
            err_cnt_ff <= err_cnt_ff + 32'h1;  // RULE16
         else if (reg_wr_go && wr_addr_ff == ADDR_INTCTL && wr_data_ff[INT_CNTCLR_BIT])
            err_cnt_ff <= WORD_RESET;  // RULE16
         if (i_ecc_evt.uncorrectable)
            flag_ff <= 1'b1;  // RULE10
         else if (reg_wr_go && wr_addr_ff == ADDR_INTCTL && wr_data_ff[INT_CLR_BIT])
            flag_ff <= 1'b0;  // RULE11
         if (intctl_ff[INT_EN_BIT] && (i_ecc_evt.uncorrectable || i_ecc_evt.corrected))
            int_n_ff <= 1'b0;  // RULE9 RULE27
         else if (reg_wr_go && wr_addr_ff == ADDR_INTCTL && wr_data_ff[INT_CLR_BIT])
            int_n_ff <= 1'b1;  // RULE11 RULE27
      end
   end

   // Register read mux, sampled by the link side only during a read data phase.
   always_comb
   begin
      case (addr_ff)
         ADDR_CFG1:      reg_rd = cfg1_ff;
         ADDR_CFG2:      reg_rd = {4'h0, cfg2_ff};  // RULE8
         ADDR_INTCTL:    reg_rd = {flag_ff, 3'h0, intctl_ff[3:0]};  // RULE10
         ADDR_UID:       reg_rd = UID_VALUE[63:56];  // RULE1
         ADDR_TEST_IN:   reg_rd = test_in_ff[31:24];  // RULE13
         ADDR_TEST_MASK: reg_rd = test_mask_ff[31:24];  // RULE14
         ADDR_TEST_OUT:  reg_rd = test_out_ff[31:24];
         ADDR_ERR_CNT:   reg_rd = err_cnt_ff[31:24];
         default:        reg_rd = 8'h00;
      endcase
   end

   assign o_int_n = int_n_ff;
   assign o_drive_impedance_select = cfg1_ff[7:5];  // RULE3
   assign o_array_write_ok = aw_ok_ff;
   assign o_protect = prot_ff;
   assign o_test_out = test_out_ff;

   a_int_hold: assert property (@(posedge i_clk) disable iff (i_rst)  // RULE27
      $fell(int_n_ff) |-> !int_n_ff [*2])
      else $error("Interrupt released early.");
   a_cnt_inc: assert property (@(posedge i_clk) disable iff (i_rst)  // RULE16
      i_ecc_evt.corrected |=> err_cnt_ff == $past(err_cnt_ff) + 32'h1)
      else $error("Counter did not step.");
   a_flag_set: assert property (@(posedge i_clk) disable iff (i_rst)  // RULE10
      i_ecc_evt.uncorrectable |=> flag_ff)
      else $error("Flag not set.");
   a_test_xor: assert property (@(posedge i_clk) disable iff (i_rst)  // RULE14
      intctl_ff[INT_TEST_BIT] |=> test_out_ff == $past(test_in_ff ^ test_mask_ff))
      else $error("Test output wrong.");
   a_sram_ok: assert property (@(posedge i_clk) disable iff (i_rst)  // RULE5
      pol == POL_SRAM |=> aw_ok_ff)
      else $error("SRAM policy blocked write.");
   a_lock_hold: assert property (@(posedge i_clk) disable iff (i_rst)  // RULE2
      cfg1_ff[CFG1_LOCK_BIT] |=> prot_ff == $past(prot_ff))
      else $error("Locked protection changed.");
   a_reg_latch: assert property (@(posedge i_clk) disable iff (i_rst)  // RULE7
      evt[2] && !latch_ff |=> cfg2_ff == $past(cfg2_ff))
      else $error("Register write without latch.");
   a_rsvd_zero: assert property (@(posedge i_clk) disable iff (i_rst)  // RULE26
      cfg1_ff[4:3] == 2'b00)
      else $error("Reserved bits set.");
   c_int_fall: cover property (@(posedge i_clk) $fell(int_n_ff));
   c_reg_write: cover property (@(posedge i_clk) reg_wr_go);
   c_latch_set: cover property (@(posedge i_clk) $rose(latch_ff));
endmodule

/* smc_host_model.sv */
// Behavioural host controller for the serial memory command block.
// Assumes a single data lane each way; the link clock runs only inside frames.
`timescale 1ns/1ns
module smc_host_model
(
   output logic      o_sck,
   output logic      o_cs_n,
   output logic      o_si,
   input  wire logic i_so,
   input  wire logic i_so_oe
);
   initial
   begin
      o_sck = 1'b0;
      o_cs_n = 1'b1;
      o_si = 1'b0;
   end

   // Data changes while the clock is low and is sampled at the rising edge.
   // Only register and write frames are sent, so no array read speed limit applies.
   task automatic shift_byte(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--)
      begin
         o_si = tx[i];
         #6 o_sck = 1'b1;
         rx[i] = i_so_oe ? i_so : 1'bx;
         #6 o_sck = 1'b0;
      end
   endtask

   // One framed instruction: command, optional address, nw data bytes, optional read byte.
   task automatic frame(input logic [7:0] op, input bit has_addr, input logic [31:0] addr,
                        input logic [31:0] wdata, input int nw, input bit rd_en,
                        output logic [7:0] rd);
      logic [7:0] junk;
      rd = 8'h00;
      o_cs_n = 1'b0;
      #6;
      shift_byte(op, junk);
      if (has_addr)
      begin
         for (int b = 3; b >= 0; b--)
            shift_byte(addr[8*b +: 8], junk);
      end
      for (int b = nw - 1; b >= 0; b--)
         shift_byte(wdata[8*b +: 8], junk);
      if (rd_en)
         shift_byte(8'h00, rd);
      #6 o_cs_n = 1'b1;
      // A released line shows the inverse of its last value, never a held copy.
      o_si = ~o_si;
      #60;
   endtask
endmodule

/* tb_top.sv */
// Self-checking testbench for the serial memory command block.
// Assumes the host model drives the link and the bench drives core-clock inputs.
`timescale 1ns/1ns
`define CHK(what, expv, gotv) \
   begin \
      checks_done++; \
      if ((gotv) !== (expv)) \
      begin \
         num_errors++; \
         $display("CHECK FAILED %s expected %h seen %h", what, expv, gotv); \
      end \
   end
module tb_top
   import smc_pkg::*;
;
   logic         clk;
   logic         rst;
   logic         sck;
   logic         cs_n;
   logic         si;
   logic         so;
   logic         so_oe;
   logic         int_n;
   logic [2:0]   drv_sel;
   logic         wr_ok;
   logic [31:0]  test_out;
   smc_ecc_evt_t ecc_evt;
   smc_protect_t protect_req;
   smc_protect_t prot;
   logic [7:0]   rd;
   int           num_errors = 0;
   int           checks_done = 0;

   smc_cmd uut (.i_clk(clk), .i_rst(rst), .i_sck(sck), .i_cs_n(cs_n), .i_si(si),
                .i_ecc_evt(ecc_evt), .i_protect_req(protect_req), .o_so(so), .o_so_oe(so_oe),
                .o_int_n(int_n), .o_drive_impedance_select(drv_sel), .o_array_write_ok(wr_ok),
                .o_protect(prot), .o_test_out(test_out));
   smc_host_model u_host (.o_sck(sck), .o_cs_n(cs_n), .o_si(si), .i_so(so), .i_so_oe(so_oe));

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic cmd(input logic [7:0] op);
      u_host.frame(op, 1'b0, 32'h0, 32'h0, 0, 1'b0, rd);
   endtask

   task automatic reg_wr(input logic [31:0] addr, input logic [31:0] data, input int nw);
      u_host.frame(OP_REG_WRITE_ADDR, 1'b1, addr, data, nw, 1'b0, rd);
   endtask

   task automatic reg_rd(input logic [31:0] addr);
      u_host.frame(OP_REG_READ_ADDR, 1'b1, addr, 32'h0, 0, 1'b1, rd);
   endtask

   task automatic pulse(input smc_ecc_evt_t ev);
      @(posedge clk);
      ecc_evt <= ev;
      @(posedge clk);
      ecc_evt <= '0;
      repeat (4) @(posedge clk);
      #1;
   endtask

   task automatic check_reset();
      `CHK("drive select", 3'h3, drv_sel)
      `CHK("write permit", 1'b1, wr_ok)
      `CHK("interrupt", 1'b1, int_n)
      `CHK("test out", 32'h0, test_out)
      reg_rd(ADDR_CFG1);
      `CHK("cfg1", 8'h61, rd)
      reg_rd(ADDR_UID);
      `CHK("serial", UID_VALUE[63:56], rd)
      reg_rd(ADDR_TEST_IN);
      `CHK("test in", 8'h00, rd)
   endtask

   task automatic check_reg_latch();
      reg_wr(ADDR_CFG1, 32'he1, 1);
      reg_rd(ADDR_CFG1);
      `CHK("cfg1 unlatched", 8'h61, rd)
      cmd(OP_WRITE_LATCH_SET);
      reg_wr(ADDR_CFG1, 32'hf9, 1);
      reg_rd(ADDR_CFG1);
      `CHK("cfg1 reserved", 8'he1, rd)
      `CHK("drive select", 3'h7, drv_sel)
      reg_wr(ADDR_CFG1, 32'h61, 1);
      reg_rd(ADDR_CFG1);
      `CHK("cfg1 latch spent", 8'he1, rd)
      cmd(OP_WRITE_LATCH_SET);
      reg_wr(ADDR_UID, 32'h00, 1);
      reg_rd(ADDR_UID);
      `CHK("serial kept", UID_VALUE[63:56], rd)
      cmd(OP_WRITE_LATCH_SET);
      reg_wr(ADDR_CFG2, 32'hf0, 1);
      reg_rd(ADDR_CFG2);
      `CHK("cfg2 reserved", 8'h00, rd)
      cmd(OP_WRITE_LATCH_SET);
      reg_wr(ADDR_CFG2, 32'h08, 1);
      u_host.frame(OP_REG_READ_ADDR, 1'b1, ADDR_CFG2, 32'h0, 1, 1'b1, rd);
      `CHK("latency read", 8'h08, rd)
      cmd(OP_WRITE_LATCH_SET);
      reg_wr(ADDR_CFG2, 32'h00, 1);
   endtask

   task automatic check_policies();
      logic [7:0] ops [4];
      logic [1:0] pol;
      ops = '{OP_WRITE_SINGLE, OP_WRITE_FAST, OP_WRITE_DDR, OP_WRITE_QUAD};
      for (int p = 0; p < 4; p++)
      begin
         pol = p[1:0];
         cmd(OP_WRITE_LATCH_SET);
         reg_wr(ADDR_CFG1, {24'h0, 6'h18, pol}, 1);
         `CHK("permit idle", pol == POL_SRAM, wr_ok)
         cmd(OP_WRITE_LATCH_SET);
         `CHK("permit latched", 1'b1, wr_ok)
         u_host.frame(ops[p], 1'b1, 32'h100, 32'ha5c3, 2, 1'b0, rd);
         `CHK("permit after write", pol == POL_SRAM || pol == POL_B2B, wr_ok)
         cmd(OP_WRITE_LATCH_CLEAR);
         `CHK("permit cleared", pol == POL_SRAM, wr_ok)
      end
      `CHK("protect taken", 4'hd, prot)
      cmd(OP_WRITE_LATCH_SET);
      reg_wr(ADDR_CFG1, 32'h65, 1);
      @(posedge clk);
      protect_req <= '{top_bottom: 1'b0, block_protect: 3'h2};
      cmd(OP_WRITE_LATCH_SET);
      `CHK("protect locked", 4'hd, prot)
      reg_wr(ADDR_CFG1, 32'h61, 1);
   endtask

   task automatic check_interrupt();
      pulse(2'b10);
      `CHK("int disabled", 1'b1, int_n)
      `CHK("count one", 32'h1, uut.err_cnt_ff)
      cmd(OP_WRITE_LATCH_SET);
      reg_wr(ADDR_INTCTL, 32'h01, 1);
      pulse(2'b01);
      `CHK("int raised", 1'b0, int_n)
      reg_rd(ADDR_INTCTL);
      `CHK("fatal flag", 1'b1, rd[7])
      reg_wr(ADDR_INTCTL, 32'h41, 1);
      `CHK("int unlatched clear", 1'b0, int_n)
      cmd(OP_WRITE_LATCH_SET);
      reg_wr(ADDR_INTCTL, 32'h21, 1);
      `CHK("int zero clear", 1'b0, int_n)
      `CHK("count cleared", 32'h0, uut.err_cnt_ff)
      cmd(OP_WRITE_LATCH_SET);
      reg_wr(ADDR_INTCTL, 32'h41, 1);
      `CHK("int cleared", 1'b1, int_n)
      reg_rd(ADDR_ERR_CNT);
      `CHK("count top", 8'h00, rd)
   endtask

   task automatic check_ecc_test();
      cmd(OP_WRITE_LATCH_SET);
      reg_wr(ADDR_TEST_IN, 32'h1234_5678, 4);
      cmd(OP_WRITE_LATCH_SET);
      reg_wr(ADDR_TEST_MASK, 32'h0000_0003, 4);
      for (int d = 0; d < 4; d++)
      begin
         cmd(OP_WRITE_LATCH_SET);
         reg_wr(ADDR_INTCTL, {28'h0, d[1:0], 2'b10}, 1);
         `CHK("test result", 32'h1234_567b, test_out)
      end
      reg_rd(ADDR_TEST_OUT);
      `CHK("test out read", 8'h12, rd)
      reg_rd(ADDR_TEST_IN);
      `CHK("test in read", 8'h12, rd)
   endtask

   task automatic give_verdict();
      $display("Checks done %0d, errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial
   begin
      rst = 1'b1;
      ecc_evt = '0;
      protect_req = '{top_bottom: 1'b1, block_protect: 3'h5};
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      #3;
      check_reset();
      check_reg_latch();
      check_policies();
      check_interrupt();
      check_ecc_test();
      give_verdict();
   end

   initial
   begin
      #900000;
      num_errors++;
      $display("CHECK FAILED run time expected finish seen hang");
      give_verdict();
   end
endmodule
